//--- design/dlc_cap_if.sv
/*
 * Carrier of the live capture values from the capture core to the
 * register read ports. Assumes one clock domain shared by both ends.
 */
interface dlc_cap_if;
    import dlc_pkg::*;
    logic [63:0] timeVal [0:DLC_NUM_TIME-1];
    logic [7:0] status1;

    modport source(output timeVal, output status1);
    modport sink(input timeVal, input status1);
endinterface

//--- design/dlc_latch_event_time_capture.sv
/*
 * Latch input and buffer event time capture of the distributed clock unit.
 * Assumes system and local time arrive as free running counters on clk,
 * that latch mode, assignment and write-acknowledge bits come from the
 * surrounding clock unit, and that buffer events are one-cycle pulses.
 */
module dlc_latch_event_time_capture
    import dlc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] captureIn,
    input wire logic [63:0] systemTime,
    input wire logic [31:0] localTime,
    input wire logic [DLC_NUM_EDGE-1:0] singleEventMode,
    input wire logic [1:0] hostAssign,
    input wire logic hostWriteAck,
    input wire logic netFrameStart,
    input wire logic netBufferEvent,
    input wire logic hostBufferStart,
    input wire logic hostBufferChange,
    input wire logic [15:0] netAddr,
    input wire logic netRd,
    input wire logic netWr,
    output logic [7:0] netRdData,
    input wire logic [15:0] hostAddr,
    input wire logic hostRd,
    input wire logic hostWr,
    output logic [7:0] hostRdData
);
    logic [1:0] rstPipe;
    logic rstSync_b;
    logic [1:0] syncStage [0:DLC_SYNC_STAGES-1];
    logic [1:0] pinLevel;
    logic [1:0] pinLast;
    logic [DLC_NUM_EDGE-1:0] edgeSeen;
    logic [DLC_NUM_EDGE-1:0] edgeTake;
    logic [DLC_NUM_EDGE-1:0] flag;
    logic [DLC_NUM_EDGE-1:0] next_flag;
    logic [DLC_NUM_EDGE-1:0] ack;
    logic [DLC_NUM_EDGE-1:0] netEdgeRead;
    logic [DLC_NUM_EDGE-1:0] hostEdgeRead;
    logic [DLC_NUM_EDGE-1:0] hostEdgeWrite;
    logic [63:0] timeReg [0:DLC_NUM_TIME-1];
    logic [31:0] frameTime;
    logic [31:0] netEvtTime;
    logic [7:0] status1;

    dlc_cap_if capBus();

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe[1];

    // Two-flop synchroniser per input, then one flop for edge detection.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            syncStage[0] <= 2'h0;
            syncStage[1] <= 2'h0;
            pinLast <= 2'h0;
        end else begin
            syncStage[0] <= captureIn;
            syncStage[1] <= syncStage[0];
            pinLast <= pinLevel;
        end
    end
    assign pinLevel = syncStage[DLC_SYNC_STAGES-1];

    // Edge events in time-register order: rise0, fall0, rise1, fall1.
    assign edgeSeen = {~pinLevel[1] & pinLast[1], pinLevel[1] & ~pinLast[1],
                       ~pinLevel[0] & pinLast[0], pinLevel[0] & ~pinLast[0]};

    // Host writes hit an edge register on any of its bytes.
    genvar e;
    generate
        for (e = 0; e < DLC_NUM_EDGE; e++) begin : g_edge
            localparam int PIN = e / 2;
            assign hostEdgeWrite[e] = hostWr && (hostAddr[15:3] == DLC_TIME_OFS[e][15:3]);
            // Acknowledge source follows the assignment and write-acknowledge bits.
            assign ack[e] = hostAssign[PIN]
                ? (hostWriteAck ? hostEdgeWrite[e] : hostEdgeRead[e])
                : netEdgeRead[e];
            // A held single-event flag blocks further captures until acknowledged.
            assign edgeTake[e] = edgeSeen[e] && !(singleEventMode[e] && flag[e]);
            // Setting wins over a same-cycle acknowledge; continuous mode forces zero.
            // An edge that meets an acknowledge keeps the flag up, but its time is not captured since the old flag still blocks it.
            assign next_flag[e] = singleEventMode[e]
                && (edgeSeen[e] || (flag[e] && !ack[e]));

            always_ff @(posedge clk or negedge rstSync_b) begin
                if (!rstSync_b) begin
                    timeReg[e] <= DLC_TIME_RESET;
                end else if (edgeTake[e]) begin
                    timeReg[e] <= systemTime;
                end
            end
        end
    endgenerate

    // Flags for all four edges; only input 1 flags are visible in status.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            flag <= 4'h0;
        end else begin
            flag <= next_flag;
        end
    end

    // The frame start time is held so a later event in the frame can use it.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            frameTime <= 32'h0;
            netEvtTime <= 32'h0;
        end else begin
            if (netFrameStart) begin
                frameTime <= localTime;
            end
            if (netBufferEvent) begin
                netEvtTime <= netFrameStart ? localTime : frameTime;
            end
        end
    end

    // Host-side buffer events take the local time directly.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            timeReg[DLC_IDX_HSTART] <= DLC_TIME_RESET;
            timeReg[DLC_IDX_HCHANGE] <= DLC_TIME_RESET;
        end else begin
            if (hostBufferStart) begin
                timeReg[DLC_IDX_HSTART] <= {32'h0, localTime};
            end
            if (hostBufferChange) begin
                timeReg[DLC_IDX_HCHANGE] <= {32'h0, localTime};
            end
        end
    end
    assign timeReg[DLC_IDX_NETEVT] = {32'h0, netEvtTime};

    // Status byte of capture input 1 with the live pin level.
    assign status1 = {5'h00, pinLevel[1], flag[DLC_IDX_FALL1],
                      flag[DLC_IDX_RISE1]};

    // Publish the live values to both read ports.
    genvar t;
    generate
        for (t = 0; t < DLC_NUM_TIME; t++) begin : g_pub
            assign capBus.timeVal[t] = timeReg[t];
        end
    endgenerate
    assign capBus.status1 = status1;

    // Network port: read only, so netWr has no path into any register.
    dlc_read_port #(.HOST_SIDE(1'b0)) u_netPort (
        .clk(clk),
        .rstSync_b(rstSync_b),
        .cap(capBus.sink),
        .addr(netAddr),
        .rd(netRd),
        .rdData(netRdData),
        .edgeRead(netEdgeRead)
    );

    // Host port keeps an independent set of snapshots.
    dlc_read_port #(.HOST_SIDE(1'b1)) u_hostPort (
        .clk(clk),
        .rstSync_b(rstSync_b),
        .cap(capBus.sink),
        .addr(hostAddr),
        .rd(hostRd),
        .rdData(hostRdData),
        .edgeRead(hostEdgeRead)
    );
endmodule

//--- design/dlc_pkg.sv
/*
 * Shared constants of the latch and event time capture block: register
 * offsets, field positions, reset values and synchroniser depth.
 * Assumes a byte-wide register access model on both register ports.
 */
package dlc_pkg;
    // Number of time registers and of latch edges.
    localparam int DLC_NUM_TIME = 7;
    localparam int DLC_NUM_EDGE = 4;

    // Time register indices; edges first so that edge index equals time index.
    localparam int DLC_IDX_RISE0 = 0;
    localparam int DLC_IDX_FALL0 = 1;
    localparam int DLC_IDX_RISE1 = 2;
    localparam int DLC_IDX_FALL1 = 3;
    localparam int DLC_IDX_NETEVT = 4;
    localparam int DLC_IDX_HSTART = 5;
    localparam int DLC_IDX_HCHANGE = 6;

    // Byte offsets of the registers.
    localparam logic [15:0] DLC_OFS_CAPTURE1_STATUS = 16'h09AF;
    localparam logic [15:0] DLC_TIME_OFS [0:DLC_NUM_TIME-1] = '{
        16'h09B0, 16'h09B8, 16'h09C0, 16'h09C8, 16'h09F0, 16'h09F8, 16'h09FC};
    // One marks a 64-bit register, zero a 32-bit register.
    localparam logic [DLC_NUM_TIME-1:0] DLC_TIME_WIDE = 7'h0F;
    // One marks a register that the network port may read.
    localparam logic [DLC_NUM_TIME-1:0] DLC_NET_VISIBLE = 7'h1F;

    // Status byte fields of capture input 1.
    localparam int DLC_ST_RISE = 0;
    localparam int DLC_ST_FALL = 1;
    localparam int DLC_ST_PIN = 2;

    // Reset values.
    localparam logic [63:0] DLC_TIME_RESET = 64'h0;
    localparam logic [7:0] DLC_STATUS_RESET = 8'h00;
    localparam logic [7:0] DLC_READ_IDLE = 8'h00;

    // Synchroniser depth for the capture inputs.
    localparam int DLC_SYNC_STAGES = 2;
endpackage

//--- design/dlc_read_port.sv
/*
 * One byte-wide register read port with its own consistency snapshots.
 * Assumes reads are single-cycle strobes synchronous to clk and that the
 * capture values arrive through the carrier interface.
 */
module dlc_read_port
    import dlc_pkg::*;
#(
    parameter bit HOST_SIDE = 1'b0
) (
    input wire logic clk,
    input wire logic rstSync_b,
    dlc_cap_if.sink cap,
    input wire logic [15:0] addr,
    input wire logic rd,
    output logic [7:0] rdData,
    output logic [DLC_NUM_EDGE-1:0] edgeRead
);
    logic [DLC_NUM_TIME-1:0] hit;
    logic [DLC_NUM_TIME-1:0] lowByte;
    logic [7:0] byteVal [0:DLC_NUM_TIME-1];
    logic [55:0] snap [0:DLC_NUM_TIME-1];
    logic [7:0] orTree [0:DLC_NUM_TIME];
    logic statusHit;
    logic [7:0] next_rdData;

    assign orTree[0] = statusHit ? cap.status1 : DLC_READ_IDLE;

    // Per-register decode, snapshot and byte selection.
    genvar i;
    generate
        for (i = 0; i < DLC_NUM_TIME; i++) begin : g_reg
            wire match64 = addr[15:3] == DLC_TIME_OFS[i][15:3];
            wire match32 = addr[15:2] == DLC_TIME_OFS[i][15:2];
            wire visible = HOST_SIDE || DLC_NET_VISIBLE[i];
            wire [2:0] lane = DLC_TIME_WIDE[i] ? addr[2:0] : {1'b0, addr[1:0]};
            wire [63:0] held = {snap[i], cap.timeVal[i][7:0]};
            assign hit[i] = rd && visible && (DLC_TIME_WIDE[i] ? match64 : match32);
            assign lowByte[i] = hit[i] && (lane == 3'h0);
            assign byteVal[i] = hit[i] ? held[8*lane +: 8] : DLC_READ_IDLE;
            assign orTree[i+1] = orTree[i] | byteVal[i];

            // Upper bits freeze on a low-byte read so later bytes stay coherent.
            always_ff @(posedge clk or negedge rstSync_b) begin
                if (!rstSync_b) begin
                    snap[i] <= 56'h0;
                end else if (lowByte[i]) begin
                    snap[i] <= cap.timeVal[i][63:8];
                end
            end
        end
    endgenerate

    // The low byte reads the live value, higher bytes read the snapshot.
    assign statusHit = rd && (addr == DLC_OFS_CAPTURE1_STATUS);
    assign next_rdData = rd ? orTree[DLC_NUM_TIME] : rdData;
    assign edgeRead = lowByte[DLC_NUM_EDGE-1:0];

    // Read data is registered and holds until the next read strobe.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            rdData <= DLC_READ_IDLE;
        end else begin
            rdData <= next_rdData;
        end
    end
endmodule

//--- tb/dc_latch_event_time_capture_tb_top.sv
/* Self-checking bench of the latch and event time capture block.
   Assumes the latch source model owns the pins; the bench drives both ports. */
module dc_latch_event_time_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dlc_pkg::*;
    logic clk = 1'h0, rst_b = 1'h0, hostWriteAck = 1'h0;
    logic [63:0] systemTime = '0, v, sv;
    logic [63:0] expT [0:6] = '{default: '0};
    logic [31:0] localTime = '0, lt, lf;
    logic [3:0] singleEventMode = '0, evt = '0, req = '0, fl = '0;
    logic [1:0] hostAssign = '0;
    logic [15:0] netAddr = '0, hostAddr = '0;
    logic [7:0] netRdData, hostRdData, d;
    logic netRd, netWr, hostRd, hostWr;
    logic netFrameStart, netBufferEvent, hostBufferStart, hostBufferChange;
    wire [1:0] captureIn;
    int failCount = 0, compares = 0;
    int unsigned st = 20000;
    // Strobes are packed so that one index picks port and kind.
    assign {hostWr, hostRd, netWr, netRd} = req;
    assign {hostBufferChange, hostBufferStart, netBufferEvent, netFrameStart} = evt;
    dlc_latch_src ext (.clk, .captureIn);
    dlc_latch_event_time_capture dut (.clk, .rst_b, .captureIn, .systemTime, .localTime,
        .singleEventMode, .hostAssign, .hostWriteAck, .netFrameStart, .netBufferEvent,
        .hostBufferStart, .hostBufferChange, .netAddr, .netRd, .netWr, .netRdData,
        .hostAddr, .hostRd, .hostWr, .hostRdData);
    // Clock of 8 ns.
    initial forever #4 clk = ~clk;
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    task automatic chk(input logic [63:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: %s %h %h", $time, m, got, exp);
        end
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Strobe op: 0 net read, 1 net write, 2 host read, 3 host write; data lands a cycle on.
    task automatic acc(input int op, input logic [15:0] a);
        @(negedge clk);
        netAddr = a;
        hostAddr = a;
        req[op] = 1'h1;
        @(negedge clk);
        req = 4'h0;
        d = op > 1 ? hostRdData : netRdData;
    endtask
    task automatic rdReg(input int op, input int i, input int b0, input int n);
        for (int b = b0; b < n; b++) begin
            acc(op, DLC_TIME_OFS[i] + 16'(b));
            v[8*b +: 8] = d;
        end
    endtask
    task automatic stChk(input int op);
        acc(op, DLC_OFS_CAPTURE1_STATUS);
        chk(d, {5'h00, captureIn[1], fl[3:2]}, "status");
    endtask
    // Model of edge k: a standing single-mode flag freezes the stored time.
    task automatic tEdge(input int k);
        systemTime = {rnd(), rnd()};
        if (!(singleEventMode[k] && fl[k]))
            expT[k] = systemTime;
        fl[k] = fl[k] | singleEventMode[k];
        ext.setPin(k / 2, !k[0]);
    endtask
    task automatic pls(input int w);
        @(negedge clk);
        lt = rnd();
        localTime = lt;
        evt[w] = 1'h1;
        @(negedge clk);
        evt = 4'h0;
        localTime = rnd();
    endtask
    // Main sequence.
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'h1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < DLC_NUM_TIME; i++) begin
            rdReg(2, i, 0, 8);
            chk(v, 64'h0, "reset");
        end
        for (int k = 0; k < 4; k++) begin
            tEdge(k);
            rdReg(2 * (k % 2), k, 0, 8);
            chk(v, expT[k], "continuous");
            stChk(2 * (k % 2));
        end
        $display("capture test done");
        singleEventMode = 4'hC;
        tEdge(2);
        tEdge(3);
        tEdge(2);
        stChk(0);
        rdReg(0, 2, 0, 8);
        chk(v, expT[2], "first rise");
        fl[2] = 1'h0;
        acc(1, 16'h09C8);
        rdReg(2, 3, 0, 8);
        chk(v, expT[3], "net write ignored");
        stChk(2);
        rdReg(0, 3, 0, 8);
        fl[3] = 1'h0;
        stChk(0);
        hostAssign = 2'h2;
        tEdge(3);
        tEdge(2);
        rdReg(0, 2, 0, 8);
        chk(v, expT[2], "net rise1");
        stChk(2);
        rdReg(2, 2, 0, 8);
        fl[2] = 1'h0;
        hostWriteAck = 1'h1;
        rdReg(2, 3, 0, 8);
        chk(v, expT[3], "host fall1");
        stChk(2);
        acc(3, 16'h09CB);
        fl[3] = 1'h0;
        stChk(0);
        $display("flag test done");
        singleEventMode = 4'h0;
        tEdge(0);
        sv = expT[0];
        rdReg(0, 0, 0, 1);
        tEdge(1);
        tEdge(0);
        rdReg(0, 0, 1, 8);
        chk(v, sv, "net snapshot");
        rdReg(2, 0, 0, 8);
        chk(v, expT[0], "host snapshot");
        // Input 0 rising edge in single mode, acknowledged by a host write.
        singleEventMode = 4'h1;
        hostAssign = 2'h3;
        tEdge(1);
        tEdge(0);
        tEdge(1);
        tEdge(0);
        rdReg(2, 0, 0, 8);
        chk(v, expT[0], "held rise0");
        acc(3, DLC_TIME_OFS[0]);
        fl[0] = 1'h0;
        tEdge(1);
        tEdge(0);
        rdReg(0, 0, 0, 8);
        chk(v, expT[0], "rearmed rise0");
        singleEventMode = 4'h0;
        $display("hold test done");
        pls(0);
        lf = lt;
        pls(1);
        rdReg(0, 4, 0, 4);
        chk(v[31:0], lf, "frame event");
        pls(2);
        rdReg(2, 5, 0, 4);
        chk(v[31:0], lt, "start event");
        pls(3);
        rdReg(2, 6, 0, 4);
        chk(v[31:0], lt, "change event");
        acc(0, 16'h09F8);
        chk(d, 8'h00, "net hidden");
        $display("event test done");
        giveVerdict();
    end
endmodule

//--- tb/dlc_chk.sv
/* Port checker of the latch and event time capture block.
   Assumes it is bound to the top module and sees its clock and reset. */
module dlc_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] captureIn,
    input wire logic [31:0] localTime,
    input wire logic [3:0] singleEventMode,
    input wire logic hostBufferStart,
    input wire logic [15:0] netAddr,
    input wire logic netRd,
    input wire logic [7:0] netRdData,
    input wire logic [15:0] hostAddr,
    input wire logic hostRd,
    input wire logic [7:0] hostRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Status reads, and the local time low byte three cycles back.
    wire netSt = netRd && netAddr == 16'h09AF;
    wire hostSt = hostRd && hostAddr == 16'h09AF;
    logic [7:0] lt1, lt2, lt3;
    always_ff @(posedge clk) {lt3, lt2, lt1} <= {lt2, lt1, localTime[7:0]};
    // A start event, a quiet cycle, then a host read of the start time low byte.
    sequence s_start;
        hostBufferStart ##1 !hostBufferStart ##1 hostRd && hostAddr == 16'h09F8;
    endsequence
    property p_stamp; s_start |=> hostRdData == lt3; endproperty
    a_stamp: assert property (p_stamp) else $error("start time wrong");
    property p_rsv; netSt |=> netRdData[7:3] == 5'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_pin;
        $stable(captureIn[1])[*4] ##0 hostSt |=> hostRdData[2] == $past(captureIn[1]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");
    property p_nCont; !singleEventMode[2] ##1 netSt && !singleEventMode[2] |=> !netRdData[0];
    endproperty
    a_nCont: assert property (p_nCont) else $error("rise flag in continuous mode");
    property p_hCont; !singleEventMode[3] ##1 hostSt && !singleEventMode[3] |=> !hostRdData[1];
    endproperty
    a_hCont: assert property (p_hCont) else $error("fall flag in continuous mode");
    property p_hide; netRd && netAddr[15:3] == 13'h013F |=> netRdData == 8'h00; endproperty
    a_hide: assert property (p_hide) else $error("host time seen on net");
    property p_hold; !netRd |=> $stable(netRdData); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule

bind dlc_latch_event_time_capture dlc_chk uChk (.clk, .rst_b, .captureIn, .localTime,
    .singleEventMode, .hostBufferStart, .netAddr, .netRd, .netRdData, .hostAddr, .hostRd,
    .hostRdData);

//--- tb/dlc_latch_src.sv
/* Model of the external latch signal source driving both capture pins.
   Assumes the bench calls setPin just after a falling clock edge. */
module dlc_latch_src (
    input wire logic clk,
    output logic [1:0] captureIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle low; each level is held six cycles so the synchroniser sees it.
    initial captureIn = 2'h0;
    task automatic setPin(input int idx, input logic lvl);
        @(negedge clk);
        captureIn[idx] = lvl;
        repeat (6) @(negedge clk);
    endtask
endmodule
